// >>> core/asc_pkg.sv
/*
 * Constants shared by the analogue sensor scaling block: sample range,
 * fault bounds, calibration defaults, output domain and timing counts.
 * Assumes a 10 MHz system clock.
 */
package asc_pkg;
    // ****************************************************************
    // sample range and checks
    // ****************************************************************
    localparam logic [9:0]  ADC_MAX         = 10'h3FF;
    localparam logic [9:0]  FAULT_LOW       = 10'h014;
    localparam logic [9:0]  FAULT_HIGH      = 10'h3C7;
    localparam logic [9:0]  CENTER_MIN      = 10'h01E;
    localparam logic [9:0]  CENTER_MAX      = 10'h3BD;
    localparam logic [9:0]  VEXT_NOMINAL    = 10'h200;
    // ****************************************************************
    // calibration points and reset values
    // ****************************************************************
    localparam logic [2:0]  PT_FULL_LEFT    = 3'h0;
    localparam logic [2:0]  PT_HALF_LEFT    = 3'h1;
    localparam logic [2:0]  PT_CENTER       = 3'h2;
    localparam logic [2:0]  PT_HALF_RIGHT   = 3'h3;
    localparam logic [2:0]  PT_FULL_RIGHT   = 3'h4;
    localparam logic [2:0]  PT_CURVE_SELECT = 3'h5;
    localparam logic [2:0]  PT_RATIOMETRIC  = 3'h6;
    localparam logic [9:0]  RST_FULL_LEFT   = 10'h064;
    localparam logic [9:0]  RST_HALF_LEFT   = 10'h12C;
    localparam logic [9:0]  RST_CENTER      = 10'h1F4;
    localparam logic [9:0]  RST_HALF_RIGHT  = 10'h2BC;
    localparam logic [9:0]  RST_FULL_RIGHT  = 10'h384;
    localparam logic [7:0]  CURVE_LINEAR    = 8'hFF;
    localparam logic [7:0]  CURVE_NONLINEAR = 8'h00;
    localparam logic [1:0]  RST_RATIOMETRIC = 2'h0;
    localparam logic [7:0]  STATUS_SET_ONE  = 8'h01;
    // ****************************************************************
    // output domain and timing
    // ****************************************************************
    localparam logic signed [11:0] OUT_FULL = 12'h3E8;
    localparam logic signed [11:0] OUT_HALF = 12'h1F4;
    localparam int AVG_DEPTH      = 5;
    localparam int CLOCK_NS       = 100;
    localparam int WINDOW_NS      = 5000000;
    localparam int SAMPLE_NS      = WINDOW_NS / AVG_DEPTH;
    localparam int SAMPLE_CYCLES  = (SAMPLE_NS + CLOCK_NS - 1) / CLOCK_NS;

    typedef enum logic {ASC_STREAM_IDLE, ASC_STREAM_ON} asc_stream_t;
endpackage

// >>> core/asc_scaler.sv
/*
 * Two-channel analogue sensor scaling: synchronise, average, compensate,
 * range-check and map samples into the -1000..+1000 calculation domain;
 * echo readings as a status stream on request.
 * Assumes sample words arrive on pins asynchronously and the calibration
 * and stream requests come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_scaler
    import asc_pkg::*;
#(
    parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // sensor pins
    input  wire logic [9:0]         analog_in_one,
    input  wire logic [9:0]         analog_in_two,
    input  wire logic [9:0]         spool_pos_reading,
    input  wire logic [9:0]         vext_reading,
    // mapping
    input  wire logic [1:0]         ch_mapped,
    input  wire logic [1:0]         actuator_channel,
    // calibration writes
    input  wire logic               cal_wr_valid,
    input  wire logic               cal_wr_channel,
    input  wire logic [2:0]         cal_wr_index,
    input  wire logic [9:0]         cal_wr_data,
    output logic                    cal_wr_done,
    output logic                    cal_wr_refused,
    // status stream
    input  wire logic               status_stream_request,
    input  wire logic               status_stream_start,
    input  wire logic [7:0]         status_set,
    input  wire logic signed [11:0] spool_setpoint,
    output logic                    stream_active,
    output logic                    status_valid,
    output logic [9:0]              status_ch1,
    output logic [9:0]              status_ch2,
    output logic [9:0]              status_spool_pos,
    output logic signed [11:0]      status_spool_setpoint,
    // scaled results
    output logic signed [11:0]      scaled_ch1,
    output logic signed [11:0]      scaled_ch2,
    output logic [1:0]              signal_fault,
    output logic signed [11:0]      actuator_position,
    output logic                    actuator_valid
);
    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [9:0] asc_average(input logic [12:0] sum);
        logic [29:0] prod;
        prod = 30'(sum) * 30'h0000CCCD;
        return prod[27:18];
    endfunction

    function automatic logic [9:0] asc_compensate(input logic [9:0] avg, input logic [9:0] vext);
        logic [19:0] q;
        q = (vext == 10'h000) ? 20'(ADC_MAX) : (20'(avg) * 20'(VEXT_NOMINAL)) / 20'(vext);
        return (q > 20'(ADC_MAX)) ? ADC_MAX : q[9:0];
    endfunction

    function automatic logic asc_monotonic(input logic [49:0] pts, input logic five);
        logic [9:0] p [5];
        logic       rise;
        logic       ok;
        for (int i = 0; i < 5; i++) p[i] = pts[i*10 +: 10];
        rise = p[4] > p[0];
        ok = p[4] != p[0];
        if (five) begin
            for (int i = 0; i < 4; i++) ok = ok && (rise ? p[i+1] > p[i] : p[i+1] < p[i]);
        end else begin
            ok = ok && (rise ? (p[2] > p[0] && p[4] > p[2]) : (p[2] < p[0] && p[4] < p[2]));
        end
        return ok;
    endfunction

    function automatic logic signed [11:0] asc_interp(input logic [9:0] s, input logic [49:0] pts,
                                                      input logic five);
        logic signed [11:0] x [5];
        logic signed [11:0] y [5];
        logic signed [11:0] sx;
        logic               rise;
        logic [2:0]         k;
        logic [2:0]         lo;
        logic [2:0]         hi;
        logic signed [23:0] num;
        logic signed [23:0] den;
        logic signed [23:0] r;
        for (int i = 0; i < 5; i++) x[i] = signed'({2'h0, pts[i*10 +: 10]});
        y[0] = -OUT_FULL;
        y[1] = -OUT_HALF;
        y[2] = 12'sh000;
        y[3] = OUT_HALF;
        y[4] = OUT_FULL;
        sx = signed'({2'h0, s});
        rise = x[4] > x[0];
        k = 3'h0;
        for (int i = 1; i < 4; i++) begin
            if ((five || i == 2) && (rise ? sx >= x[i] : sx <= x[i])) k = 3'(i);
        end
        lo = five ? k : ((k < 3'h2) ? 3'h0 : 3'h2);
        hi = five ? 3'(k + 3'h1) : 3'(lo + 3'h2);
        num = 24'(sx - x[lo]) * 24'(y[hi] - y[lo]);
        den = 24'(x[hi] - x[lo]);
        r = (den == 24'sh0) ? 24'(y[lo]) : 24'(y[lo]) + num / den;
        if (r > 24'(OUT_FULL)) r = 24'(OUT_FULL);
        if (r < -24'(OUT_FULL)) r = -24'(OUT_FULL);
        return 12'(r);
    endfunction

    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_pipe_reg;
    logic       rst_n_sync;
    logic [9:0] pin_s1_reg [4];
    logic [9:0] pin_s2_reg [4];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_pipe_reg[1];

    always_ff @(posedge clock or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            for (int i = 0; i < 4; i++) begin
                pin_s1_reg[i] <= 10'h000;
                pin_s2_reg[i] <= 10'h000;
            end
        end else begin
            pin_s1_reg[0] <= analog_in_one;
            pin_s1_reg[1] <= analog_in_two;
            pin_s1_reg[2] <= spool_pos_reading;
            pin_s1_reg[3] <= vext_reading;
            for (int i = 0; i < 4; i++) pin_s2_reg[i] <= pin_s1_reg[i];
        end
    end

    // ****************************************************************
    // sample tick and running average
    // ****************************************************************
    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic        tick;
    logic [9:0]  hist_reg  [2][AVG_DEPTH];
    logic [9:0]  hist_next [2][AVG_DEPTH];
    logic [9:0]  avg       [2];
    logic [9:0]  checked   [2];
    logic [1:0]  ratiometric_select_reg;

    always_comb begin
        tick = tick_cnt_reg == 16'(SAMPLE_PERIOD - 1);
        tick_cnt_next = tick ? 16'h0000 : 16'(tick_cnt_reg + 16'h0001);
        hist_next = hist_reg;
        for (int c = 0; c < 2; c++) begin
            if (tick) begin
                for (int i = AVG_DEPTH - 1; i > 0; i--) hist_next[c][i] = hist_reg[c][i-1];
                hist_next[c][0] = pin_s2_reg[c];
            end
            avg[c] = asc_average(13'(hist_reg[c][0]) + 13'(hist_reg[c][1]) + 13'(hist_reg[c][2])
                                 + 13'(hist_reg[c][3]) + 13'(hist_reg[c][4]));
            checked[c] = ratiometric_select_reg[c] ? asc_compensate(avg[c], pin_s2_reg[3])
                                                  : avg[c];
        end
    end

    always_ff @(posedge clock or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            tick_cnt_reg <= 16'h0000;
            for (int c = 0; c < 2; c++) begin
                for (int i = 0; i < AVG_DEPTH; i++) hist_reg[c][i] <= 10'h000;
            end
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            hist_reg <= hist_next;
        end
    end

    // ****************************************************************
    // calibration store
    // ****************************************************************
    logic [49:0] pts_reg      [2];
    logic [49:0] pts_next     [2];
    logic [7:0]  curve_reg    [2];
    logic [7:0]  curve_next   [2];
    logic [1:0]  ratio_next;
    logic [49:0] cand;
    logic [7:0]  cand_curve;
    logic        wr_ok;
    logic        done_next;
    logic        refused_next;

    always_comb begin
        pts_next = pts_reg;
        curve_next = curve_reg;
        ratio_next = ratiometric_select_reg;
        cand = pts_reg[cal_wr_channel];
        cand_curve = curve_reg[cal_wr_channel];
        if (cal_wr_index <= PT_FULL_RIGHT) cand[cal_wr_index*10 +: 10] = cal_wr_data;
        if (cal_wr_index == PT_CURVE_SELECT) cand_curve = cal_wr_data[7:0];
        wr_ok = (cal_wr_index == PT_RATIOMETRIC) ? cal_wr_data[9:2] == 8'h00
              : (cal_wr_index <= PT_CURVE_SELECT)
                && (cal_wr_index != PT_CURVE_SELECT || cal_wr_data[9:8] == 2'h0)
                && (cand_curve == CURVE_LINEAR || cand_curve == CURVE_NONLINEAR)
                && asc_monotonic(cand, cand_curve == CURVE_NONLINEAR)
                && cand[20 +: 10] >= CENTER_MIN && cand[20 +: 10] <= CENTER_MAX;
        done_next = cal_wr_valid && wr_ok;
        refused_next = cal_wr_valid && !wr_ok;
        if (done_next) begin
            if (cal_wr_index == PT_RATIOMETRIC) begin
                ratio_next = cal_wr_data[1:0];
            end else begin
                pts_next[cal_wr_channel] = cand;
                curve_next[cal_wr_channel] = cand_curve;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            for (int c = 0; c < 2; c++) begin
                pts_reg[c] <= {RST_FULL_RIGHT, RST_HALF_RIGHT, RST_CENTER, RST_HALF_LEFT,
                               RST_FULL_LEFT};
                curve_reg[c] <= CURVE_LINEAR;
            end
            ratiometric_select_reg <= RST_RATIOMETRIC;
            cal_wr_done <= 1'b0;
            cal_wr_refused <= 1'b0;
        end else begin
            pts_reg <= pts_next;
            curve_reg <= curve_next;
            ratiometric_select_reg <= ratio_next;
            cal_wr_done <= done_next;
            cal_wr_refused <= refused_next;
        end
    end

    // ****************************************************************
    // scaling, range check, actuator and status stream
    // ****************************************************************
    logic signed [11:0] scaled_next [2];
    logic [1:0]         fault_next;
    logic signed [11:0] act_next;
    logic               act_valid_next;
    asc_stream_t        stream_reg;
    asc_stream_t        stream_next;
    logic               svalid_next;
    logic [9:0]         sch1_next;
    logic [9:0]         sch2_next;
    logic [9:0]         spos_next;
    logic signed [11:0] sset_next;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            scaled_next[c] = asc_interp(checked[c], pts_reg[c],
                                        curve_reg[c] == CURVE_NONLINEAR);
            fault_next[c] = ch_mapped[c]
                            && (checked[c] < FAULT_LOW || checked[c] > FAULT_HIGH);
        end
        act_valid_next = actuator_channel == 2'h1 || actuator_channel == 2'h2;
        act_next = (actuator_channel == 2'h2) ? scaled_next[1] : scaled_next[0];
        stream_next = stream_reg;
        if (status_stream_request && status_set == STATUS_SET_ONE) begin
            stream_next = status_stream_start ? ASC_STREAM_ON : ASC_STREAM_IDLE;
        end
        case (stream_reg)
            ASC_STREAM_IDLE: svalid_next = 1'b0;
            ASC_STREAM_ON:   svalid_next = tick;
            default:         svalid_next = 1'b0;
        endcase
        sch1_next = svalid_next ? avg[0] : status_ch1;
        sch2_next = svalid_next ? avg[1] : status_ch2;
        spos_next = svalid_next ? pin_s2_reg[2] : status_spool_pos;
        sset_next = svalid_next ? spool_setpoint : status_spool_setpoint;
    end

    always_ff @(posedge clock or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            scaled_ch1 <= 12'sh000;
            scaled_ch2 <= 12'sh000;
            signal_fault <= 2'h0;
            actuator_position <= 12'sh000;
            actuator_valid <= 1'b0;
            stream_reg <= ASC_STREAM_IDLE;
            status_valid <= 1'b0;
            status_ch1 <= 10'h000;
            status_ch2 <= 10'h000;
            status_spool_pos <= 10'h000;
            status_spool_setpoint <= 12'sh000;
        end else begin
            scaled_ch1 <= scaled_next[0];
            scaled_ch2 <= scaled_next[1];
            signal_fault <= fault_next;
            actuator_position <= act_next;
            actuator_valid <= act_valid_next;
            stream_reg <= stream_next;
            status_valid <= svalid_next;
            status_ch1 <= sch1_next;
            status_ch2 <= sch2_next;
            status_spool_pos <= spos_next;
            status_spool_setpoint <= sset_next;
        end
    end
    assign stream_active = stream_reg == ASC_STREAM_ON;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking asc_cb @(posedge clock); endclocking
    default disable iff (!rst_n_sync);

    a_fault_low_set: assert property (ch_mapped[0] && checked[0] < FAULT_LOW |=> signal_fault[0])
        else $error("low sample did not raise fault");
    a_fault_in_range: assert property (ch_mapped[1] && checked[1] >= FAULT_LOW
        && checked[1] <= FAULT_HIGH |=> !signal_fault[1])
        else $error("in-range sample raised fault");
    a_ratio_off_raw: assert property (!ratiometric_select_reg[0] |-> checked[0] == avg[0])
        else $error("uncompensated channel changed");
    a_refused_write_kept: assert property (cal_wr_valid && !wr_ok |=> cal_wr_refused
        && $stable(pts_reg[0]) && $stable(pts_reg[1]) && $stable(curve_reg[0]))
        else $error("refused write altered calibration");
    a_center_write_stored: assert property (cal_wr_valid && wr_ok && !cal_wr_channel
        && cal_wr_index == PT_CENTER |=> pts_reg[0][20 +: 10] == $past(cal_wr_data))
        else $error("accepted center write not stored");
    a_left_maps_full: assert property (checked[0] == pts_reg[0][9:0]
        |=> scaled_ch1 == -OUT_FULL)
        else $error("full-left point not mapped to -1000");
    a_center_maps_zero: assert property (checked[1] == pts_reg[1][29:20]
        |=> scaled_ch2 == 12'sh000)
        else $error("center point not mapped to zero");
    a_stream_start_on: assert property (status_stream_request && status_stream_start
        && status_set == STATUS_SET_ONE |=> stream_active)
        else $error("status set one did not start stream");
    a_stream_echo_data: assert property (stream_active && tick && !status_stream_request
        |=> status_valid && status_spool_setpoint == $past(spool_setpoint)
        && status_ch1 == $past(avg[0]))
        else $error("status echo data wrong");

    c_refused_write: cover property (cal_wr_valid && !wr_ok);
    c_stream_beat:   cover property (status_valid);
    c_fault_seen:    cover property (signal_fault != 2'h0);
    c_five_point:    cover property (curve_reg[0] == CURVE_NONLINEAR && scaled_ch1 == OUT_HALF);
endmodule
`default_nettype wire

// >>> verification/analog_sensor_scaling_tb.sv
/*
 * Self-checking bench for asc_scaler: integer model of calibration,
 * compensation, range check, interpolation and the status echo.
 * Assumes a short SAMPLE_PERIOD so the averages settle quickly.
 */
`timescale 1ns/1ps
`default_nettype none
module analog_sensor_scaling_tb;
    import asc_pkg::*;
    logic        clock, rst_b, cal_wr_valid, cal_wr_channel, cal_wr_done, cal_wr_refused;
    logic        status_stream_request, status_stream_start, stream_active, status_valid;
    logic        actuator_valid;
    logic [1:0]  ch_mapped, actuator_channel, signal_fault;
    logic [2:0]  cal_wr_index;
    logic [7:0]  status_set;
    logic [9:0]  cal_wr_data, l1, l2, lsp, lvx, a1, a2, asp, avx;
    logic [9:0]  status_ch1, status_ch2, status_spool_pos;
    logic signed [11:0] spool_setpoint, status_spool_setpoint, scaled_ch1, scaled_ch2;
    logic signed [11:0] actuator_position;
    int          miscompares, samples_checked, pt[2][5], lin[2], comp, k, v;
    int          faults[7] = '{10, 19, 20, 500, 967, 968, 1023};

    asc_sensor_model sensors (.clock(clock), .lvl_one(l1), .lvl_two(l2), .lvl_spool(lsp),
        .lvl_vext(lvx), .analog_in_one(a1), .analog_in_two(a2), .spool_pos_reading(asp),
        .vext_reading(avx));
    asc_scaler #(.SAMPLE_PERIOD(4)) uut (.clock(clock), .rst_b(rst_b), .analog_in_one(a1),
        .analog_in_two(a2), .spool_pos_reading(asp), .vext_reading(avx),
        .ch_mapped(ch_mapped), .actuator_channel(actuator_channel),
        .cal_wr_valid(cal_wr_valid), .cal_wr_channel(cal_wr_channel),
        .cal_wr_index(cal_wr_index), .cal_wr_data(cal_wr_data), .cal_wr_done(cal_wr_done),
        .cal_wr_refused(cal_wr_refused), .status_stream_request(status_stream_request),
        .status_stream_start(status_stream_start), .status_set(status_set),
        .spool_setpoint(spool_setpoint), .stream_active(stream_active),
        .status_valid(status_valid), .status_ch1(status_ch1), .status_ch2(status_ch2),
        .status_spool_pos(status_spool_pos), .status_spool_setpoint(status_spool_setpoint),
        .scaled_ch1(scaled_ch1), .scaled_ch2(scaled_ch2), .signal_fault(signal_fault),
        .actuator_position(actuator_position), .actuator_valid(actuator_valid));

    // ****************************************************************
    // model
    // ****************************************************************
    function int eff(int c);
        int r;
        r = (c ? l2 : l1);
        if ((comp >> c) & 1)
            r = (r * 512 / lvx > 1023) ? 1023 : r * 512 / lvx;
        return r;
    endfunction
    function int scl(int c);
        int s, st, j, r;
        s = eff(c);
        st = lin[c] ? 2 : 1;
        r = 1000;
        for (j = 4 - st; j >= 0; j -= st)
            if (s < pt[c][j+st])
                r = -1000 + 500 * j + (s - pt[c][j]) * 500 * st / (pt[c][j+st] - pt[c][j]);
        return (s <= pt[c][0]) ? -1000 : r;
    endfunction
    function bit mono(int c);
        int j, st;
        bit up, dn;
        st = lin[c] ? 2 : 1;
        up = 1;
        dn = 1;
        for (j = 0; j < 4; j += st) begin
            up &= pt[c][j] < pt[c][j+st];
            dn &= pt[c][j] > pt[c][j+st];
        end
        return (up | dn) && pt[c][2] >= 30 && pt[c][2] <= 957;
    endfunction

    // ****************************************************************
    // tasks
    // ****************************************************************
    task step();
        @(posedge clock);
        #10;
    endtask
    task check(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task settle(input int a, input int b);
        l1 = 10'(a);
        l2 = 10'(b);
        repeat (40) step();
        check(scaled_ch1, 12'(scl(0)));
        check(scaled_ch2, 12'(scl(1)));
        check(12'(signal_fault), 12'({eff(1) < 20 || eff(1) > 967, eff(0) < 20 || eff(0) > 967}));
    endtask
    task cal(input int c, input int i, input int d);
        int old;
        bit ok;
        ok = 0;
        if (i < 5) begin
            old = pt[c][i];
            pt[c][i] = d;
            ok = mono(c);
            if (!ok) pt[c][i] = old;
        end else if (i == 5) begin
            old = lin[c];
            lin[c] = (d == 255);
            ok = (d == 0 || d == 255) && mono(c);
            if (!ok) lin[c] = old;
        end else if (i == 6 && d <= 3) begin
            ok = 1;
            comp = d;
        end
        step();
        cal_wr_valid = 1;
        cal_wr_channel = 1'(c);
        cal_wr_index = 3'(i);
        cal_wr_data = 10'(d);
        step();
        cal_wr_valid = 0;
        check(12'({cal_wr_done, cal_wr_refused}), 12'({ok, !ok}));
    endtask
    task req(input logic st, input logic [7:0] set);
        step();
        status_stream_request = 1;
        status_stream_start = st;
        status_set = set;
        step();
        status_stream_request = 0;
    endtask
    task print_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    initial begin
        #2000000;
        miscompares++;
        print_verdict();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        {rst_b, cal_wr_valid, cal_wr_channel, status_stream_request, status_stream_start} = 0;
        {cal_wr_index, cal_wr_data, status_set, actuator_channel} = 0;
        miscompares = 0;
        samples_checked = 0;
        pt = '{'{100, 300, 500, 700, 900}, '{100, 300, 500, 700, 900}};
        lin = '{1, 1};
        comp = 0;
        void'($urandom(12880));
        ch_mapped = 2'h3;
        spool_setpoint = 12'($urandom_range(0, 4095));
        {l1, l2, lsp, lvx} = {10'h1F4, 10'h1F4, 10'($urandom), 10'h200};
        repeat (8) @(posedge clock);
        #10;
        rst_b = 1;
        repeat (3) step();
        settle(100 + 2 * $urandom_range(0, 399), 500);
        foreach (faults[k]) settle(faults[k], 900 - k);
        cal(0, 2, 450);
        settle(450, 500);
        for (k = 0; k < 6; k++) cal(k % 2, 2 + k / 2 * 2, 950 - 900 * (k / 4));
        cal(0, 7, 300);
        cal(0, 5, 7);
        cal(0, 2, 500);
        cal(0, 5, 0);
        cal(0, 1, 600);
        settle(100 + 2 * $urandom_range(0, 399), 300);
        cal(1, 5, 255);
        cal(0, 6, 4);
        cal(1, 6, 1);
        lvx = 10'h100;
        settle(490, 490);
        cal(0, 6, 3);
        settle(470, 490);
        for (k = 0; k < 4; k++) begin
            actuator_channel = 2'(k);
            step();
            step();
            check(12'(actuator_valid), 12'(k == 1 || k == 2));
            if (k == 1 || k == 2) check(actuator_position, 12'(scl(k - 1)));
        end
        req(1, 8'h02);
        check(12'(stream_active), 12'h000);
        req(1, STATUS_SET_ONE);
        check(12'(stream_active), 12'h001);
        for (v = 0; v < 20 && status_valid !== 1'b1; v++) step();
        check(12'(status_valid), 12'h001);
        step();
        check(12'(status_ch1), 12'(l1));
        check(12'(status_ch2), 12'(l2));
        check(12'(status_spool_pos), 12'(lsp));
        check(status_spool_setpoint, spool_setpoint);
        req(0, STATUS_SET_ONE);
        check(12'(stream_active), 12'h000);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verification/asc_sensor_model.sv
/*
 * Far-side stand-in: the two steering sensors, the spool position sensor
 * and the supply measurement, presented as asynchronous pin words.
 * Assumes the bench chooses the levels; the pins follow them off the edge.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_sensor_model (
    // clock
    input  wire logic       clock,
    // requested levels
    input  wire logic [9:0] lvl_one,
    input  wire logic [9:0] lvl_two,
    input  wire logic [9:0] lvl_spool,
    input  wire logic [9:0] lvl_vext,
    // sensor pins
    output logic      [9:0] analog_in_one,
    output logic      [9:0] analog_in_two,
    output logic      [9:0] spool_pos_reading,
    output logic      [9:0] vext_reading
);
    // pins move away from the sampling edge, as an unsynchronised source would
    always @(posedge clock) begin
        #37;
        analog_in_one     <= lvl_one;
        analog_in_two     <= lvl_two;
        spool_pos_reading <= lvl_spool;
        vext_reading      <= lvl_vext;
    end
endmodule
`default_nettype wire
